// *** core/pin_select_pkg.sv ***
package pin_select_pkg;

  // ----------------------------------------------------------------
  // register map (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam logic [3:0] DTC_IN1_ADDR = 4'h0;
  localparam logic [3:0] DTC_IN23_ADDR = 4'h1;
  localparam logic [3:0] DTC_IN45_ADDR = 4'h2;
  localparam logic [3:0] DTC_IN6_ADDR = 4'h3;
  localparam logic [3:0] OUT_MAP0_ADDR = 4'h4;
  localparam logic [3:0] OUT_MAP1_ADDR = 4'h5;
  localparam logic [3:0] OUT_MAP2_ADDR = 4'h6;
  localparam logic [3:0] OUT_MAP3_ADDR = 4'h7;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int unsigned IN_SEL_W = 7;
  localparam int unsigned OUT_SEL_W = 6;
  localparam int unsigned HI_LSB = 8;
  localparam int unsigned LO_LSB = 0;
  localparam int unsigned NUM_DTC_IN = 6;

  // ----------------------------------------------------------------
  // input selector codes and reset values
  // ----------------------------------------------------------------
  localparam logic [6:0] SEL_GROUND = 7'h00;
  localparam logic [6:0] SEL_COMPARATOR_ONE_OUTPUT = 7'h01;
  localparam logic [6:0] SEL_PIN124 = 7'h7C;
  localparam int unsigned NUM_PINS = 128;
  localparam logic [6:0] IN_SEL_RESET = 7'h00;
  localparam logic [5:0] OUT_SEL_RESET = 6'h00;
  localparam logic [15:0] READ_ZERO = 16'h0000;

endpackage

// *** core/pin_select_dtc_out.sv ***
// Notes on behaviour
// RULE_01: input selector code 1111100 routes remappable input pin 124.
// RULE_02: input selector code 0000001 routes comparator one output.
// RULE_03: input selector code 0000000 ties the input to ground.
// RULE_04: input 1 selector in bits 14-8; bit 15 and 7-0 read zero.
// RULE_05: input 3 selector bits 14-8, input 2 bits 6-0; 15, 7 zero.
// RULE_06: input 5 selector bits 14-8, input 4 bits 6-0, seven bits each.
// RULE_07: input 6 selector in bits 6-0; bits 15-7 unimplemented.
// RULE_08: unimplemented bits always read zero regardless of writes.
// RULE_09: output map 0: bits 13-8 pin 35 code, bits 5-0 pin 20 code.
// RULE_10: output map 1: bits 13-8 pin 37 code, bits 5-0 pin 36 code.
// RULE_11: output map 2: bits 13-8 pin 39 code, bits 5-0 pin 38 code.
// RULE_12: output map 3: bits 13-8 pin 41 code, bits 5-0 pin 40 code.
// RULE_13: output map bits 15-14 and 7-6 read zero.
// RULE_14: every selector bit clears to zero at reset.
// RULE_15: every selector field reads back exactly as written.
// RULE_16: codes 2 through 124 each pick one remappable pin by number.
// RULE_17: writes to unimplemented bits are ignored and affect no routing.
`timescale 1ns/10ps
`default_nettype none

module pin_select_dtc_out
  import pin_select_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  input  wire logic [ADDR_W-1:0]    reg_addr,
  input  wire logic [DATA_W-1:0]    reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output var  logic [DATA_W-1:0]    reg_rdata,
  input  wire logic [NUM_PINS-1:0]  remappable_pin,
  input  wire logic                 comparator_one_output,
  output var  logic [5:0]           deadtime_comp_in,
  output var  logic [OUT_SEL_W-1:0] pin20_function_code,
  output var  logic [OUT_SEL_W-1:0] pin35_function_code,
  output var  logic [OUT_SEL_W-1:0] pin36_function_code,
  output var  logic [OUT_SEL_W-1:0] pin37_function_code,
  output var  logic [OUT_SEL_W-1:0] pin38_function_code,
  output var  logic [OUT_SEL_W-1:0] pin39_function_code,
  output var  logic [OUT_SEL_W-1:0] pin40_function_code,
  output var  logic [OUT_SEL_W-1:0] pin41_function_code
);

  // ----------------------------------------------------------------
  // selector storage
  // ----------------------------------------------------------------
  logic [IN_SEL_W-1:0] dtc_sel_q [NUM_DTC_IN];
  logic [NUM_PINS-1:0] pin_meta_q;
  logic [NUM_PINS-1:0] pin_sync_q;
  logic                cmp_meta_q;
  logic                cmp_sync_q;
  logic [DATA_W-1:0]   rdata_d;

  // reads a selector code: ground, comparator, or a pin by number
  // codes past pin 124 fall through to a quiet low, never to an unknown pin
  function automatic logic route_sel(input logic [IN_SEL_W-1:0] sel,
                                     input logic [NUM_PINS-1:0] pins,
                                     input logic cmp);
    logic r;
    r = 1'b0;
    if (sel == SEL_GROUND)
      r = 1'b0; // RULE_03
    else if (sel == SEL_COMPARATOR_ONE_OUTPUT)
      r = cmp; // RULE_02
    else if (sel <= SEL_PIN124)
      r = pins[sel]; // RULE_01 RULE_16
    return r;
  endfunction

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NUM_DTC_IN; i++)
        dtc_sel_q[i] <= IN_SEL_RESET; // RULE_14
    end
    else if (reg_wr)
    begin
      // only implemented field bits are captured; the rest is dropped
      unique case (reg_addr)
        DTC_IN1_ADDR:
          dtc_sel_q[0] <= reg_wdata[HI_LSB +: IN_SEL_W]; // RULE_04 RULE_17
        DTC_IN23_ADDR:
        begin
          dtc_sel_q[2] <= reg_wdata[HI_LSB +: IN_SEL_W]; // RULE_05
          dtc_sel_q[1] <= reg_wdata[LO_LSB +: IN_SEL_W]; // RULE_05
        end
        DTC_IN45_ADDR:
        begin
          dtc_sel_q[4] <= reg_wdata[HI_LSB +: IN_SEL_W]; // RULE_06
          dtc_sel_q[3] <= reg_wdata[LO_LSB +: IN_SEL_W]; // RULE_06
        end
        DTC_IN6_ADDR:
          dtc_sel_q[5] <= reg_wdata[LO_LSB +: IN_SEL_W]; // RULE_07
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      pin20_function_code <= OUT_SEL_RESET; // RULE_14
      pin35_function_code <= OUT_SEL_RESET;
      pin36_function_code <= OUT_SEL_RESET;
      pin37_function_code <= OUT_SEL_RESET;
      pin38_function_code <= OUT_SEL_RESET;
      pin39_function_code <= OUT_SEL_RESET;
      pin40_function_code <= OUT_SEL_RESET;
      pin41_function_code <= OUT_SEL_RESET;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        OUT_MAP0_ADDR:
        begin
          pin35_function_code <= reg_wdata[HI_LSB +: OUT_SEL_W]; // RULE_09
          pin20_function_code <= reg_wdata[LO_LSB +: OUT_SEL_W]; // RULE_09
        end
        OUT_MAP1_ADDR:
        begin
          pin37_function_code <= reg_wdata[HI_LSB +: OUT_SEL_W]; // RULE_10
          pin36_function_code <= reg_wdata[LO_LSB +: OUT_SEL_W]; // RULE_10
        end
        OUT_MAP2_ADDR:
        begin
          pin39_function_code <= reg_wdata[HI_LSB +: OUT_SEL_W]; // RULE_11
          pin38_function_code <= reg_wdata[LO_LSB +: OUT_SEL_W]; // RULE_11
        end
        OUT_MAP3_ADDR:
        begin
          pin41_function_code <= reg_wdata[HI_LSB +: OUT_SEL_W]; // RULE_12
          pin40_function_code <= reg_wdata[LO_LSB +: OUT_SEL_W]; // RULE_12
        end
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin and comparator synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end
    else
    begin
      // bits settle one by one, so pins that move together may land a cycle apart
      pin_meta_q <= remappable_pin;
      pin_sync_q <= pin_meta_q;
      cmp_meta_q <= comparator_one_output;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // routing to the dead-time compensation inputs
  // ----------------------------------------------------------------
  // registered so the outputs come straight from flip-flops; costs one cycle
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      deadtime_comp_in <= '0;
    else
      for (int i = 0; i < NUM_DTC_IN; i++)
        deadtime_comp_in[i] <= route_sel(dtc_sel_q[i], pin_sync_q, cmp_sync_q);
  end

  // ----------------------------------------------------------------
  // read-back
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_d = READ_ZERO; // RULE_08 RULE_13
    unique case (reg_addr)
      DTC_IN1_ADDR:
        rdata_d[HI_LSB +: IN_SEL_W] = dtc_sel_q[0]; // RULE_15
      DTC_IN23_ADDR:
      begin
        rdata_d[HI_LSB +: IN_SEL_W] = dtc_sel_q[2];
        rdata_d[LO_LSB +: IN_SEL_W] = dtc_sel_q[1];
      end
      DTC_IN45_ADDR:
      begin
        rdata_d[HI_LSB +: IN_SEL_W] = dtc_sel_q[4];
        rdata_d[LO_LSB +: IN_SEL_W] = dtc_sel_q[3];
      end
      DTC_IN6_ADDR:
        rdata_d[LO_LSB +: IN_SEL_W] = dtc_sel_q[5];
      OUT_MAP0_ADDR:
      begin
        rdata_d[HI_LSB +: OUT_SEL_W] = pin35_function_code;
        rdata_d[LO_LSB +: OUT_SEL_W] = pin20_function_code;
      end
      OUT_MAP1_ADDR:
      begin
        rdata_d[HI_LSB +: OUT_SEL_W] = pin37_function_code;
        rdata_d[LO_LSB +: OUT_SEL_W] = pin36_function_code;
      end
      OUT_MAP2_ADDR:
      begin
        rdata_d[HI_LSB +: OUT_SEL_W] = pin39_function_code;
        rdata_d[LO_LSB +: OUT_SEL_W] = pin38_function_code;
      end
      OUT_MAP3_ADDR:
      begin
        rdata_d[HI_LSB +: OUT_SEL_W] = pin41_function_code;
        rdata_d[LO_LSB +: OUT_SEL_W] = pin40_function_code;
      end
      default:
        rdata_d = READ_ZERO;
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      reg_rdata <= READ_ZERO;
    else if (reg_rd)
      reg_rdata <= rdata_d; // RULE_15
    else
      reg_rdata <= READ_ZERO;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ground_tie: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_03
    (dtc_sel_q[0] == SEL_GROUND) && $stable(dtc_sel_q[0]) |=> !deadtime_comp_in[0])
    else $error("input 1 not grounded");

  a_cmp_route: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_02
    (dtc_sel_q[1] == SEL_COMPARATOR_ONE_OUTPUT) |=> deadtime_comp_in[1] == $past(cmp_sync_q))
    else $error("input 2 not fed by comparator");

  a_pin124_route: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_01
    (dtc_sel_q[5] == SEL_PIN124) |=> deadtime_comp_in[5] == $past(pin_sync_q[124]))
    else $error("input 6 not fed by pin 124");

  a_in1_field: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_04
    reg_wr && reg_addr == DTC_IN1_ADDR |=> reg_rd && reg_addr == DTC_IN1_ADDR
      |=> reg_rdata == {1'b0, $past(reg_wdata[14:8], 2), 8'h00})
    else $error("input 1 register read-back wrong");

  a_in6_unimpl: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_07
    $past(reg_rd) && $past(reg_addr) == DTC_IN6_ADDR |-> reg_rdata[15:7] == 9'h000)
    else $error("input 6 upper bits not zero");

  a_zero_bits: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_08
    reg_rdata[15] == 1'b0)
    else $error("bit 15 read non-zero");

  a_out_unimpl: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_13
    $past(reg_rd) && $past(reg_addr) >= OUT_MAP0_ADDR
      |-> reg_rdata[15:14] == 2'h0 && reg_rdata[7:6] == 2'h0)
    else $error("output map unimplemented bits set");

  a_map0_write: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_09
    reg_wr && reg_addr == OUT_MAP0_ADDR
      |=> pin35_function_code == $past(reg_wdata[13:8])
        && pin20_function_code == $past(reg_wdata[5:0]))
    else $error("output map 0 not updated");

  // checked at the release edge: before the first reset edge the flops hold unknowns
  a_reset_clear: assert property (@(posedge ref_clk) // RULE_14
    $rose(nrst) |-> dtc_sel_q[0] == IN_SEL_RESET
      && dtc_sel_q[1] == IN_SEL_RESET
      && dtc_sel_q[2] == IN_SEL_RESET
      && dtc_sel_q[3] == IN_SEL_RESET
      && dtc_sel_q[4] == IN_SEL_RESET
      && dtc_sel_q[5] == IN_SEL_RESET
      && pin20_function_code == OUT_SEL_RESET
      && pin35_function_code == OUT_SEL_RESET
      && pin36_function_code == OUT_SEL_RESET
      && pin37_function_code == OUT_SEL_RESET
      && pin38_function_code == OUT_SEL_RESET
      && pin39_function_code == OUT_SEL_RESET
      && pin40_function_code == OUT_SEL_RESET
      && pin41_function_code == OUT_SEL_RESET
      && deadtime_comp_in == '0
      && reg_rdata == READ_ZERO)
    else $error("selector not cleared by reset");

  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_15
    !$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");

  // ----------------------------------------------------------------
  // selector write paths
  // ----------------------------------------------------------------
  a_in23_write: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_05
    reg_wr && reg_addr == DTC_IN23_ADDR
      |=> dtc_sel_q[2] == $past(reg_wdata[HI_LSB +: IN_SEL_W])
        && dtc_sel_q[1] == $past(reg_wdata[LO_LSB +: IN_SEL_W]))
    else $error("input 2 or 3 selector not updated");

  a_in45_write: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_06
    reg_wr && reg_addr == DTC_IN45_ADDR
      |=> dtc_sel_q[4] == $past(reg_wdata[HI_LSB +: IN_SEL_W])
        && dtc_sel_q[3] == $past(reg_wdata[LO_LSB +: IN_SEL_W]))
    else $error("input 4 or 5 selector not updated");

  a_in6_write: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_07
    reg_wr && reg_addr == DTC_IN6_ADDR
      |=> dtc_sel_q[5] == $past(reg_wdata[LO_LSB +: IN_SEL_W]))
    else $error("input 6 selector not updated");

  a_map1_write: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_10
    reg_wr && reg_addr == OUT_MAP1_ADDR
      |=> pin37_function_code == $past(reg_wdata[HI_LSB +: OUT_SEL_W])
        && pin36_function_code == $past(reg_wdata[LO_LSB +: OUT_SEL_W]))
    else $error("output map 1 not updated");

  a_map2_write: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_11
    reg_wr && reg_addr == OUT_MAP2_ADDR
      |=> pin39_function_code == $past(reg_wdata[HI_LSB +: OUT_SEL_W])
        && pin38_function_code == $past(reg_wdata[LO_LSB +: OUT_SEL_W]))
    else $error("output map 2 not updated");

  a_map3_write: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_12
    reg_wr && reg_addr == OUT_MAP3_ADDR
      |=> pin41_function_code == $past(reg_wdata[HI_LSB +: OUT_SEL_W])
        && pin40_function_code == $past(reg_wdata[LO_LSB +: OUT_SEL_W]))
    else $error("output map 3 not updated");

  // a stray write above the map must leave every selector alone
  a_stray_write: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_17
    reg_wr && reg_addr > OUT_MAP3_ADDR
      |=> $stable({dtc_sel_q[0], dtc_sel_q[1], dtc_sel_q[2], dtc_sel_q[3], dtc_sel_q[4]})
        && $stable({dtc_sel_q[5], pin20_function_code, pin35_function_code})
        && $stable({pin36_function_code, pin37_function_code, pin38_function_code})
        && $stable({pin39_function_code, pin40_function_code, pin41_function_code}))
    else $error("write outside the map changed a selector");

  // ----------------------------------------------------------------
  // routing of pin codes, codes past the last pin and the ground code
  // ----------------------------------------------------------------
  a_pin_route: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_16
    dtc_sel_q[0] > SEL_COMPARATOR_ONE_OUTPUT && dtc_sel_q[0] <= SEL_PIN124
      |=> deadtime_comp_in[0] == $past(pin_sync_q[dtc_sel_q[0]]))
    else $error("input 1 not fed by the selected pin");

  a_high_code: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_16
    dtc_sel_q[3] > SEL_PIN124 |=> !deadtime_comp_in[3])
    else $error("input 4 not low for a code past the last pin");

  a_in6_ground: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_03
    dtc_sel_q[5] == SEL_GROUND |=> !deadtime_comp_in[5])
    else $error("input 6 not grounded");

  c_pin_route: cover property (@(posedge ref_clk) disable iff (!nrst)
    dtc_sel_q[0] == SEL_PIN124 ##1 deadtime_comp_in[0]);
  c_cmp_route: cover property (@(posedge ref_clk) disable iff (!nrst)
    dtc_sel_q[2] == SEL_COMPARATOR_ONE_OUTPUT ##1 deadtime_comp_in[2]);
  c_map_readback: cover property (@(posedge ref_clk) disable iff (!nrst)
    reg_wr && reg_addr == OUT_MAP3_ADDR ##1 reg_rd && reg_addr == OUT_MAP3_ADDR);
  c_high_code: cover property (@(posedge ref_clk) disable iff (!nrst)
    dtc_sel_q[3] > SEL_PIN124 ##1 !deadtime_comp_in[3]);
  c_stray_write: cover property (@(posedge ref_clk) disable iff (!nrst)
    reg_wr && reg_addr > OUT_MAP3_ADDR);

endmodule

`default_nettype wire

// *** sim/pin_far_side.sv ***
`timescale 1ns/10ps
`default_nettype none

module pin_far_side
(
  input  wire logic         ref_clk,
  input  wire logic         load,
  input  wire logic [127:0] next_pins,
  input  wire logic         next_cmp,
  output var  logic [127:0] pins,
  output var  logic         cmp
);
  // board levels only move on a load, so every level stands far longer than the sync delay
  initial pins = 128'h0;
  initial cmp = 1'b0;
  always @(posedge ref_clk)
  begin
    if (load)
    begin
      pins <= next_pins;
      cmp <= next_cmp;
    end
  end
endmodule

`default_nettype wire

// *** sim/remappable_pin_select_dtc_and_outputs_bench.sv ***
`timescale 1ns/10ps
`default_nettype none

module remappable_pin_select_dtc_and_outputs_bench
  import pin_select_pkg::*;
;
  logic                 ref_clk = 1'b0;
  logic                 nrst = 1'b0;
  logic [ADDR_W-1:0]    reg_addr = 4'h0;
  logic [DATA_W-1:0]    reg_wdata = 16'h0000;
  logic [DATA_W-1:0]    reg_rdata;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic                 load = 1'b0;
  logic                 next_cmp = 1'b0;
  logic                 cmp;
  logic [NUM_PINS-1:0]  next_pins = 128'h0;
  logic [NUM_PINS-1:0]  pins;
  logic [5:0]           comp_in;
  logic [5:0]           e;
  logic [OUT_SEL_W-1:0] fc [8];
  logic [15:0]          mdl [16];
  logic [15:0]          d;
  logic [6:0]           c;
  int                   err_total = 0;
  int                   comparisons = 0;

  always #2.5 ref_clk = ~ref_clk;

  pin_far_side i_pin_far_side (.ref_clk(ref_clk), .load(load), .next_pins(next_pins),
    .next_cmp(next_cmp), .pins(pins), .cmp(cmp));

  pin_select_dtc_out i_pin_select_dtc_out (.ref_clk(ref_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .remappable_pin(pins), .comparator_one_output(cmp),
    .deadtime_comp_in(comp_in), .pin20_function_code(fc[0]), .pin35_function_code(fc[1]),
    .pin36_function_code(fc[2]), .pin37_function_code(fc[3]), .pin38_function_code(fc[4]),
    .pin39_function_code(fc[5]), .pin40_function_code(fc[6]), .pin41_function_code(fc[7]));

  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  function automatic logic [15:0] mask(int a);
    case (a)
      0: return 16'h7F00;
      1, 2: return 16'h7F7F;
      3: return 16'h007F;
      4, 5, 6, 7: return 16'h3F3F;
      default: return 16'h0000;
    endcase
  endfunction

  function automatic logic route(int i);
    logic [6:0] s;
    s = (i % 2) ? mdl[i/2][14:8] : mdl[i/2][6:0];
    if (s == 7'h00) return 1'b0;
    if (s == 7'h01) return next_cmp;
    // codes past the last pin number give a quiet low
    if (s <= 7'h7C) return next_pins[s];
    return 1'b0;
  endfunction

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  task automatic wr_reg(int a, logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a[3:0];
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    mdl[a] = v & mask(a);
  endtask

  task automatic rd_chk(int a);
    @(posedge ref_clk);
    reg_addr <= a[3:0];
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, mdl[a]);
  endtask

  // write then read with no idle cycle between the strobes
  task automatic wr_rd_chk(int a, logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a[3:0];
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    mdl[a] = v & mask(a);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, mdl[a]);
  endtask

  task automatic all_chk();
    for (int a = 0; a < 16; a++)
      rd_chk(a);
    for (int p = 0; p < 8; p++)
      chk("function_code", {10'h000, fc[p]},
        {10'h000, (p % 2) ? mdl[4 + p/2][13:8] : mdl[4 + p/2][5:0]});
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    // the tests take under a thousand cycles; four thousand means a hang
    #20000;
    err_total++;
    give_verdict();
  end

  initial
  begin
    void'($urandom(39272));
    for (int a = 0; a < 16; a++)
      mdl[a] = 16'h0000;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    all_chk();
    chk("deadtime_comp_in", {10'h000, comp_in}, 16'h0000);
    $display("test reset_values done");
    repeat (4)
    begin
      for (int a = 0; a < 16; a++)
        wr_reg(a, 16'($urandom));
      all_chk();
    end
    $display("test write_read done");
    for (int a = 0; a < 8; a++)
      wr_rd_chk(a, 16'($urandom));
    all_chk();
    $display("test back_to_back done");
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int a = 0; a < 16; a++)
      mdl[a] = 16'h0000;
    all_chk();
    chk("deadtime_comp_in", {10'h000, comp_in}, 16'h0000);
    $display("test second_reset done");
    for (int i = 1; i <= 6; i++)
      for (int k = 0; k < 6; k++)
      begin
        // ground, comparator, pin 124, some pin, a code past the pins, any code from 2 to 127
        c = (k == 0) ? 7'h00 : (k == 1) ? 7'h01 : (k == 2) ? 7'h7C
          : (k == 3) ? 7'($urandom_range(2, 124))
          : (k == 4) ? 7'($urandom_range(125, 127)) : 7'($urandom_range(2, 127));
        d = mdl[i/2];
        if (i % 2)
          d[14:8] = c;
        else
          d[6:0] = c;
        wr_reg(i/2, d | 16'h8080);
        @(posedge ref_clk);
        next_pins <= {$urandom, $urandom, $urandom, $urandom};
        next_cmp <= 1'($urandom);
        load <= 1'b1;
        @(posedge ref_clk);
        load <= 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
        for (int j = 1; j <= 6; j++)
          e[j-1] = route(j);
        chk("deadtime_comp_in", {10'h000, comp_in}, {10'h000, e});
      end
    $display("test routing done");
    give_verdict();
  end
endmodule

`default_nettype wire
